// File: dps_pkg.sv
package dps_pkg;

    // Register byte offsets
    localparam logic [7:0] DPS_ADDR_CTRL  = 8'h00;
    localparam logic [7:0] DPS_ADDR_STAT  = 8'h04;

    // Control register fields
    localparam int         DPS_CTRL_SOFT1   = 0;
    localparam int         DPS_CTRL_SOFT2   = 1;
    localparam int         DPS_CTRL_IGNPIN  = 2;
    localparam int         DPS_CTRL_AUTORC  = 3;
    localparam int         DPS_CTRL_ALERTEN = 4;
    localparam int         DPS_CTRL_ATTEN   = 5;
    localparam int         DPS_CTRL_W       = 6;
    localparam logic [5:0] DPS_CTRL_RESET   = 6'h38;

    // Status register fields
    localparam int         DPS_STAT_BVFLG   = 0;
    localparam int         DPS_STAT_REMFLG  = 1;
    localparam int         DPS_STAT_ERRFLG  = 2;
    localparam int         DPS_STAT_STATE   = 4;
    localparam int         DPS_STAT_SMBUS   = 8;
    localparam int         DPS_STAT_LIMIT   = 9;

    // Strap decode: upper bit selects stand-alone, lower bits the limit
    localparam int         DPS_STRAP_MODE   = 3;

    // Default interval lengths in clock cycles
    localparam int         DPS_MASK_CYC     = 16;
    localparam int         DPS_CYCLE_CYC    = 200;
    localparam int         DPS_DISCH_CYC    = 20;
    localparam int         DPS_IDLE_CYC     = 100;
    localparam int         DPS_CNT_W        = 16;

    typedef enum logic [2:0] {
        ST_SLEEP, ST_DETECT, ST_DISCH, ST_ACTIVE, ST_ERROR, ST_REMOVE
    } dps_state_e;

    typedef struct packed {
        logic       die_hot;
        logic       over_cur;
        logic       port_uv;
        logic       disch_err;
        logic       src_ov;
        logic [1:0] back_volt;
    } dps_fault_s;

    typedef struct packed {
        logic [1:0] port_sw;
        logic       bypass;
        logic [1:0] discharge;
        logic       attach_det;
        logic       removal_det;
    } dps_sw_s;

endpackage

// File: dps_power_ctrl.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// Function
// RQ1 - Detect moves to Active on attach when enabled and supplies valid
// RQ2 - Detect-to-Active: attach detect off, bypass off, discharge pulse, then switch on
// RQ3 - No Active state while source below lockout or both enables off
// RQ4 - Active enters Error on heat, overcurrent, undervoltage, backdrive, discharge, overvoltage
// RQ5 - Detect enters Error only on back-drive or over-temperature
// RQ6 - Sleep enters Error on back-drive
// RQ7 - Error opens port and bypass switches, asserts alert by default
// RQ8 - Auto-recovery waits recovery period, rechecks faults, returns Active or Detect; code returns Sleep when both enables are off
// RQ9 - Removal in Error rechecks faults then returns to the state inputs define
// RQ10 - Strap code picks SMBus or stand-alone mode and one of eight limits
// RQ11 - Enable pins active-high in SMBus mode, active-low stand-alone
// RQ12 - Back-voltage monitoring runs in Sleep, Detect and Active
// RQ13 - Back-voltage opens switch at once; past mask time enters Error
// RQ14 - Qualified back-voltage opens bypass too and sets event flag
// RQ15 - Source overvoltage beyond mask time opens switch and enters Error
// RQ16 - Port switch stays open while that port's enable is off
// RQ17 - SMBus mode: ignore pins bit uses soft bits only, else combines
// RQ18 - Sleep only with both enables off; all switches open, alerts released
// RQ19 - First read in Sleep wakes and returns zero; idle timeout re-sleeps
// RQ20 - Removal opens switches, flags, discharges, then returns to Detect
// RQ21 - Mask, recovery and discharge intervals are parameterised cycle counters
module dps_power_ctrl
    import dps_pkg::*;
#(
    parameter int MASK_CYC  = DPS_MASK_CYC,
    parameter int CYCLE_CYC = DPS_CYCLE_CYC,
    parameter int DISCH_CYC = DPS_DISCH_CYC,
    parameter int IDLE_CYC  = DPS_IDLE_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pins and analog monitors
    input  wire logic [1:0]  port_power_enable_i,
    input  wire logic [3:0]  mode_limit_strap_i,
    input  wire logic        core_ok_i,
    input  wire logic        src_ok_i,
    input  wire dps_fault_s  fault_i,
    input  wire logic [1:0]  attach_i,
    input  wire logic [1:0]  removal_i,
    // Switch controls and alerts
    output dps_sw_s          sw_o,
    output logic      [1:0]  alert_o,
    output logic      [1:0]  alert_oe_o,
    output logic             smbus_mode_o,
    output logic      [2:0]  current_limit_setting_o
);

    localparam logic [DPS_CNT_W-1:0] MASK_N  = DPS_CNT_W'(MASK_CYC);
    localparam logic [DPS_CNT_W-1:0] CYCLE_N = DPS_CNT_W'(CYCLE_CYC - 1);
    localparam logic [DPS_CNT_W-1:0] DISCH_N = DPS_CNT_W'(DISCH_CYC - 1);
    localparam logic [DPS_CNT_W-1:0] IDLE_N  = DPS_CNT_W'(IDLE_CYC);
    localparam logic [DPS_CNT_W-1:0] ONE     = DPS_CNT_W'(1);

    if (MASK_CYC < 1 || CYCLE_CYC < 1 || DISCH_CYC < 1 || IDLE_CYC < 1 ||
        MASK_CYC > 65535 || CYCLE_CYC > 65535 || DISCH_CYC > 65535 ||
        IDLE_CYC > 65535) begin : g_bad_param
        $error("dps_power_ctrl: interval parameters out of range");
    end

    // State
    dps_state_e             state_reg, state_next;
    logic [DPS_CNT_W-1:0]   timer_reg, timer_next;
    logic [DPS_CNT_W-1:0]   bv_cnt_reg, bv_cnt_next;
    logic [DPS_CNT_W-1:0]   ov_cnt_reg, ov_cnt_next;
    logic [DPS_CNT_W-1:0]   idle_reg, idle_next;
    logic                   awake_reg, awake_next;
    logic                   was_act_reg, was_act_next;
    logic [DPS_CTRL_W-1:0]  ctrl_reg, ctrl_next;
    logic [2:0]             flags_reg, flags_next;
    logic                   strap_done_reg, strap_done_next;
    logic                   smbus_reg, smbus_next;
    logic [2:0]             limit_reg, limit_next;
    dps_sw_s                sw_reg, sw_next;
    logic [1:0]             alert_oe_reg, alert_oe_next;
    logic [31:0]            prdata_reg, prdata_next;
    logic                   pready_reg, pready_next;
    logic                   pslverr_reg, pslverr_next;

    // Derived conditions
    logic [1:0] pin_act;
    logic [1:0] eff_en;
    logic       en_any, can_active, bv_any, bv_mon, bv_qual, ov_qual;
    logic       act_fault, all_clear, attach_hit;
    logic       setup, wr_acc, rd_acc, sleepy_rd;
    dps_state_e home;

    always_comb begin
        pin_act = smbus_reg ? port_power_enable_i : ~port_power_enable_i;  // see RQ11
        if (smbus_reg) begin
            eff_en = {ctrl_reg[DPS_CTRL_SOFT2], ctrl_reg[DPS_CTRL_SOFT1]};
            if (!ctrl_reg[DPS_CTRL_IGNPIN]) begin
                eff_en = eff_en & pin_act;  // see RQ17
            end
        end else begin
            eff_en = pin_act;
        end
        en_any     = |eff_en;
        can_active = en_any & src_ok_i & core_ok_i;  // see RQ3
        bv_any     = |fault_i.back_volt;
        bv_mon     = (state_reg != ST_ERROR) && (state_reg != ST_REMOVE);  // see RQ12
        bv_qual    = bv_cnt_reg == MASK_N;
        ov_qual    = ov_cnt_reg == MASK_N;
        act_fault  = fault_i.die_hot | fault_i.over_cur | fault_i.port_uv |
                     fault_i.disch_err | ov_qual | bv_qual;  // see RQ4
        all_clear  = ~(fault_i.die_hot | fault_i.over_cur | fault_i.port_uv |
                       fault_i.disch_err | fault_i.src_ov | bv_any);
        attach_hit = ~ctrl_reg[DPS_CTRL_ATTEN] | (|(attach_i & eff_en));
        if (can_active && was_act_reg) begin
            home = ST_ACTIVE;
        end else if (en_any) begin
            home = ST_DETECT;
        end else begin
            home = ST_SLEEP;
        end
        setup     = psel_i & ~penable_i;
        wr_acc    = psel_i & penable_i & pready_reg & pwrite_i;
        rd_acc    = psel_i & penable_i & pready_reg & ~pwrite_i;
        sleepy_rd = (state_reg == ST_SLEEP) && !awake_reg;
    end

    // Power state sequencing
    always_comb begin
        state_next   = state_reg;
        timer_next   = timer_reg;
        was_act_next = was_act_reg;
        bv_cnt_next  = '0;
        ov_cnt_next  = '0;
        if (bv_any && bv_mon) begin
            bv_cnt_next = bv_qual ? bv_cnt_reg : bv_cnt_reg + ONE;  // see RQ21
        end
        if (fault_i.src_ov) begin
            ov_cnt_next = ov_qual ? ov_cnt_reg : ov_cnt_reg + ONE;  // see RQ15
        end
        unique case (state_reg)
            ST_SLEEP: begin
                if (bv_qual) begin
                    state_next = ST_ERROR;  // see RQ6
                end else if (en_any && core_ok_i) begin
                    state_next = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (bv_qual || fault_i.die_hot) begin
                    state_next = ST_ERROR;  // see RQ5
                end else if (!en_any) begin
                    state_next = ST_SLEEP;  // see RQ18
                end else if (|removal_i) begin
                    state_next = ST_REMOVE;
                end else if (can_active && attach_hit) begin
                    state_next = ST_DISCH;  // see RQ1
                    timer_next = DISCH_N;
                end
            end
            ST_DISCH: begin
                if (act_fault) begin
                    state_next = ST_ERROR;
                end else if (!can_active) begin
                    state_next = en_any ? ST_DETECT : ST_SLEEP;
                end else if (timer_reg == '0) begin
                    state_next = ST_ACTIVE;  // see RQ2
                end else begin
                    timer_next = timer_reg - ONE;
                end
            end
            ST_ACTIVE: begin
                if (act_fault) begin
                    state_next = ST_ERROR;  // see RQ4
                end else if (|removal_i) begin
                    state_next = ST_REMOVE;
                end else if (!can_active) begin
                    state_next = en_any ? ST_DETECT : ST_SLEEP;  // see RQ3
                end
            end
            ST_ERROR: begin
                if (|removal_i && all_clear) begin
                    state_next = home;  // see RQ9
                end else if (ctrl_reg[DPS_CTRL_AUTORC]) begin
                    if (timer_reg != '0) begin
                        timer_next = timer_reg - ONE;
                    end else if (all_clear) begin
                        state_next = home;  // see RQ8
                    end else begin
                        timer_next = CYCLE_N;
                    end
                end
            end
            ST_REMOVE: begin
                if (timer_reg == '0) begin
                    state_next = ST_DETECT;  // see RQ20
                end else begin
                    timer_next = timer_reg - ONE;
                end
            end
        endcase
        if (state_next == ST_ERROR && state_reg != ST_ERROR) begin
            timer_next   = CYCLE_N;
            was_act_next = (state_reg == ST_ACTIVE) || (state_reg == ST_DISCH);
        end
        if (state_next == ST_REMOVE && state_reg != ST_REMOVE) begin
            timer_next = DISCH_N;
        end
    end

    // Switch and alert drive, registered from the next state
    always_comb begin
        sw_next             = '0;
        sw_next.bypass      = (state_next == ST_DETECT) && !bv_any;  // see RQ14
        sw_next.discharge   = {2{(state_next == ST_DISCH) || (state_next == ST_REMOVE)}};
        sw_next.attach_det  = (state_next == ST_DETECT) && ctrl_reg[DPS_CTRL_ATTEN];
        sw_next.removal_det = (state_next == ST_DETECT) || (state_next == ST_ACTIVE)
                              || (state_next == ST_DISCH);
        if (state_next == ST_ACTIVE && !bv_any) begin
            sw_next.port_sw = eff_en;  // see RQ13 see RQ16
        end
        alert_oe_next = {2{(state_next == ST_ERROR) && ctrl_reg[DPS_CTRL_ALERTEN]}};  // see RQ7
    end

    // Strap capture, sleep wake and register file
    always_comb begin
        strap_done_next = 1'b1;
        smbus_next      = smbus_reg;
        limit_next      = limit_reg;
        if (!strap_done_reg) begin
            smbus_next = ~mode_limit_strap_i[DPS_STRAP_MODE];  // see RQ10
            limit_next = mode_limit_strap_i[2:0];
        end
        awake_next = 1'b0;
        idle_next  = '0;
        if (state_reg == ST_SLEEP) begin
            awake_next = awake_reg;
            idle_next  = idle_reg;
            if (psel_i) begin
                idle_next = '0;
                if (rd_acc) begin
                    awake_next = 1'b1;  // see RQ19
                end
            end else if (awake_reg) begin
                if (idle_reg == IDLE_N) begin
                    awake_next = 1'b0;
                end else begin
                    idle_next = idle_reg + ONE;
                end
            end
        end
        ctrl_next  = ctrl_reg;
        flags_next = flags_reg;
        if (wr_acc && paddr_i == DPS_ADDR_CTRL) begin
            ctrl_next = pwdata_i[DPS_CTRL_W-1:0];
        end
        if (wr_acc && paddr_i == DPS_ADDR_STAT) begin
            flags_next = flags_reg & ~pwdata_i[2:0];
        end
        if (bv_qual) begin
            flags_next[DPS_STAT_BVFLG] = 1'b1;  // see RQ14
        end
        if (state_next == ST_REMOVE && state_reg != ST_REMOVE) begin
            flags_next[DPS_STAT_REMFLG] = 1'b1;
        end
        if (state_next == ST_ERROR && state_reg != ST_ERROR) begin
            flags_next[DPS_STAT_ERRFLG] = 1'b1;
        end
        pready_next  = setup;
        pslverr_next = setup && paddr_i != DPS_ADDR_CTRL && paddr_i != DPS_ADDR_STAT;
        prdata_next  = '0;
        if (setup && !pwrite_i &&
            !(state_next == ST_SLEEP && !(state_reg == ST_SLEEP && awake_reg))) begin
            if (paddr_i == DPS_ADDR_CTRL) begin
                prdata_next[DPS_CTRL_W-1:0] = ctrl_reg;
            end else if (paddr_i == DPS_ADDR_STAT) begin
                prdata_next[DPS_STAT_BVFLG +: 3] = flags_reg;
                prdata_next[DPS_STAT_STATE +: 3] = state_reg;
                prdata_next[DPS_STAT_SMBUS]      = smbus_reg;
                prdata_next[DPS_STAT_LIMIT +: 3] = limit_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg      <= ST_SLEEP;
            timer_reg      <= '0;
            bv_cnt_reg     <= '0;
            ov_cnt_reg     <= '0;
            idle_reg       <= '0;
            awake_reg      <= 1'b0;
            was_act_reg    <= 1'b0;
            ctrl_reg       <= DPS_CTRL_RESET;
            flags_reg      <= '0;
            strap_done_reg <= 1'b0;
            smbus_reg      <= 1'b1;
            limit_reg      <= '0;
            sw_reg         <= '0;
            alert_oe_reg   <= '0;
            prdata_reg     <= '0;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
        end else begin
            state_reg      <= state_next;
            timer_reg      <= timer_next;
            bv_cnt_reg     <= bv_cnt_next;
            ov_cnt_reg     <= ov_cnt_next;
            idle_reg       <= idle_next;
            awake_reg      <= awake_next;
            was_act_reg    <= was_act_next;
            ctrl_reg       <= ctrl_next;
            flags_reg      <= flags_next;
            strap_done_reg <= strap_done_next;
            smbus_reg      <= smbus_next;
            limit_reg      <= limit_next;
            sw_reg         <= sw_next;
            alert_oe_reg   <= alert_oe_next;
            prdata_reg     <= prdata_next;
            pready_reg     <= pready_next;
            pslverr_reg    <= pslverr_next;
        end
    end

    assign prdata_o                = prdata_reg;
    assign pready_o                = pready_reg;
    assign pslverr_o               = pslverr_reg;
    assign sw_o                    = sw_reg;
    assign alert_o                 = 2'h0;
    assign alert_oe_o              = alert_oe_reg;
    assign smbus_mode_o            = smbus_reg;
    assign current_limit_setting_o = limit_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_detect_attach_go: assert property (  // see RQ1
        state_reg == ST_DETECT && can_active && attach_hit && !bv_qual &&
        !fault_i.die_hot && !(|removal_i) |=> state_reg == ST_DISCH)
        else $error("attach in detect did not start discharge");
    a_disch_switches: assert property (  // see RQ2
        state_reg == ST_DISCH |-> sw_o.discharge == 2'h3 && !sw_o.bypass &&
        sw_o.port_sw == 2'h0 && !sw_o.attach_det && sw_o.removal_det)
        else $error("discharge phase switch settings wrong");
    a_active_needs_src: assert property (  // see RQ3
        |sw_o.port_sw |-> state_reg == ST_ACTIVE && $past(src_ok_i) && $past(en_any))
        else $error("port switch closed without supply or enable");
    a_port_en_gate: assert property (  // see RQ16
        sw_o.port_sw[0] |-> $past(eff_en[0]))
        else $error("port switch closed with its enable off");
    a_active_fault_err: assert property (  // see RQ4
        state_reg == ST_ACTIVE && fault_i.over_cur |=> state_reg == ST_ERROR)
        else $error("overcurrent in active did not enter error");
    a_detect_err_cause: assert property (  // see RQ5
        state_reg == ST_DETECT ##1 state_reg == ST_ERROR |->
        $past(bv_qual || fault_i.die_hot))
        else $error("detect left for error without cause");
    a_sleep_bv_err: assert property (  // see RQ6
        state_reg == ST_SLEEP && bv_qual |=> state_reg == ST_ERROR)
        else $error("back-drive in sleep did not enter error");
    a_error_opens: assert property (  // see RQ7
        state_reg == ST_ERROR |-> sw_o.port_sw == 2'h0 && !sw_o.bypass &&
        (alert_oe_o == {2{ctrl_reg[DPS_CTRL_ALERTEN]}} || $changed(ctrl_reg)))
        else $error("error state switches or alert wrong");
    a_enable_polarity: assert property (  // see RQ11
        strap_done_reg && !smbus_reg && port_power_enable_i[0] |=> !sw_o.port_sw[0])
        else $error("stand-alone high enable pin closed the switch");
    a_bv_opens_now: assert property (  // see RQ13
        bv_any |=> sw_o.port_sw == 2'h0 && !sw_o.bypass)
        else $error("back-voltage did not open switches");
    a_bv_flag_set: assert property (  // see RQ14
        bv_qual |=> flags_reg[DPS_STAT_BVFLG])
        else $error("back-voltage flag not set");
    a_ov_mask_err: assert property (  // see RQ15
        state_reg == ST_ACTIVE && ov_qual |=> state_reg == ST_ERROR)
        else $error("overvoltage past mask did not enter error");
    a_sleep_quiet: assert property (  // see RQ18
        state_reg == ST_SLEEP |-> sw_o == '0 && alert_oe_o == 2'h0)
        else $error("sleep left a switch or alert on");
    a_wake_read_zero: assert property (  // see RQ19
        rd_acc && sleepy_rd |-> prdata_o == 32'h0 ##1 awake_reg || state_reg != ST_SLEEP)
        else $error("wake read not zero or did not wake");
    a_remove_done: assert property (  // see RQ20
        state_reg == ST_REMOVE && timer_reg == '0 |=> state_reg == ST_DETECT)
        else $error("removal discharge did not return to detect");

endmodule

// File: dps_host_model.sv
`timescale 1ns/100ps
module dps_host_model (
    // Strap level and host intent
    input  wire logic       standalone_i,
    input  wire logic [1:0] en_req_i,
    input  wire logic [1:0] alert_oe_i,
    input  wire logic [1:0] alert_i,
    // Pin levels
    output logic      [1:0] port_power_enable_o,
    output logic      [1:0] alert_n_o
);
    // Enable pins take the polarity the strap selects
    assign port_power_enable_o = standalone_i ? ~en_req_i : en_req_i;
    // Open-drain alert lines: driven level while enabled, else pull-up
    assign alert_n_o = (alert_oe_i & alert_i) | ~alert_oe_i;
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    import dps_pkg::*;
    localparam int DIS  = 5;
    localparam int IDLE = 200;
    logic       clk_i   = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       psel    = 1'b0;
    logic       penable = 1'b0;
    logic       pwrite  = 1'b0;
    logic       src_ok  = 1'b1;
    logic [7:0] paddr   = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] en_req  = 2'h0;
    logic [1:0] attach  = 2'h0;
    logic [1:0] removal = 2'h0;
    logic [3:0] strap   = 4'h5;
    dps_fault_s flt     = '0;
    logic [31:0] prdata, rd;
    logic       pready, pslverr, smbus, rerr;
    logic [1:0] pin_en, alert_oe, alert_n, alert;
    logic [2:0] lim;
    dps_sw_s    sw;
    int         fails = 0;
    int         samples_checked = 0;
    int         cyc = 0;

    always #25 clk_i = ~clk_i;

    dps_power_ctrl #(.MASK_CYC(4), .CYCLE_CYC(30), .DISCH_CYC(DIS), .IDLE_CYC(IDLE)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .port_power_enable_i(pin_en), .mode_limit_strap_i(strap),
        .core_ok_i(1'b1), .src_ok_i(src_ok), .fault_i(flt),
        .attach_i(attach), .removal_i(removal), .sw_o(sw),
        .alert_o(alert), .alert_oe_o(alert_oe), .smbus_mode_o(smbus),
        .current_limit_setting_o(lim)
    );

    dps_host_model host (
        .standalone_i(strap[3]), .en_req_i(en_req),
        .alert_oe_i(alert_oe), .alert_i(alert),
        .port_power_enable_o(pin_en), .alert_n_o(alert_n)
    );

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_state(input dps_state_e s);
        int n;
        n = 0;
        do begin
            apb(1'b0, DPS_ADDR_STAT, 32'h0);
            n++;
        end while (rd[DPS_STAT_STATE +: 3] !== 3'(s) && n < 40);
        `CHK(rd[DPS_STAT_STATE +: 3], 3'(s))
    endtask

    task automatic pulse(input logic rem);
        if (rem) removal <= 2'h1;
        else attach <= 2'h1;
        @(posedge clk_i);
        removal <= 2'h0;
        attach <= 2'h0;
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask

    initial begin
        do_reset();
        `CHK(smbus, 1'b1);
        `CHK(lim, 3'h5);
        apb(1'b0, DPS_ADDR_STAT, 32'h0);
        `CHK(rd, 32'h0);
        apb(1'b0, DPS_ADDR_STAT, 32'h0);
        `CHK(rd[11:8], 4'hb);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rerr, 1'b1);
        en_req <= 2'h1;
        apb(1'b1, DPS_ADDR_CTRL, 32'h3b);
        wait_state(ST_DETECT);
        src_ok <= 1'b0;
        pulse(1'b0);
        repeat (DIS + 4) @(posedge clk_i);
        `CHK(sw.port_sw, 2'h0);
        src_ok <= 1'b1;
        pulse(1'b0);
        @(posedge clk_i);
        `CHK({sw.discharge, sw.bypass, sw.attach_det, sw.removal_det}, 5'h19);
        wait_state(ST_ACTIVE);
        `CHK(sw.port_sw, 2'h1);
        flt.over_cur <= 1'b1;
        wait_state(ST_ERROR);
        `CHK({sw.port_sw, sw.bypass, alert_n}, 5'h0);
        flt.over_cur <= 1'b0;
        apb(1'b0, DPS_ADDR_STAT, 32'h0);
        `CHK(rd[DPS_STAT_STATE +: 3], 3'(ST_ERROR));
        wait_state(ST_ACTIVE);
        apb(1'b1, DPS_ADDR_CTRL, 32'h33);
        flt.src_ov <= 1'b1;
        wait_state(ST_ERROR);
        flt.src_ov <= 1'b0;
        repeat (40) @(posedge clk_i);
        apb(1'b0, DPS_ADDR_STAT, 32'h0);
        `CHK(rd[DPS_STAT_STATE +: 3], 3'(ST_ERROR));
        pulse(1'b1);
        wait_state(ST_ACTIVE);
        apb(1'b1, DPS_ADDR_CTRL, 32'h3b);
        pulse(1'b1);
        wait_state(ST_DETECT);
        `CHK(rd[DPS_STAT_REMFLG], 1'b1);
        flt.back_volt <= 2'h2;
        wait_state(ST_ERROR);
        `CHK(rd[DPS_STAT_BVFLG], 1'b1);
        flt.back_volt <= 2'h0;
        wait_state(ST_DETECT);
        en_req <= 2'h0;
        wait_state(ST_SLEEP);
        `CHK({sw, alert_n}, 9'h003);
        repeat (IDLE + 10) @(posedge clk_i);
        apb(1'b0, DPS_ADDR_STAT, 32'h0);
        `CHK(rd, 32'h0);
        strap <= 4'hb;
        en_req <= 2'h2;
        do_reset();
        `CHK({smbus, lim}, 4'h3);
        apb(1'b0, DPS_ADDR_STAT, 32'h0);
        wait_state(ST_DETECT);
        en_req <= 2'h0;
        wait_state(ST_SLEEP);
        stop_test();
    end
endmodule
